// file: include/esiu_defs.vh
// Constants for the eight-source interrupt unit
`ifndef ESIU_DEFS_VH
`define ESIU_DEFS_VH
// ------------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ------------------------------------------------------------------
`define ESIU_IDX_SAVED_FLAGS 8'hcf
`define ESIU_IDX_INT_MASK 8'hfd
`define ESIU_IDX_INT_REQUEST 8'hfe
`define ESIU_IDX_FLAGS 8'hff
`define ESIU_IDX_SYS_CTL 8'hd5
`define ESIU_IDX_STATUS 8'hc0
`define ESIU_ADDR_W 10
`define ESIU_ADDR_SAVED_FLAGS 10'h33c
`define ESIU_ADDR_INT_MASK 10'h3f4
`define ESIU_ADDR_INT_REQUEST 10'h3f8
`define ESIU_ADDR_FLAGS 10'h3fc
`define ESIU_ADDR_SYS_CTL 10'h354
`define ESIU_ADDR_STATUS 10'h300
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ESIU_GIE_BIT 0
`define ESIU_SRC_EXT_FIRST 3
`define ESIU_SRC_EXT_SECOND 6
`define ESIU_SRC_TIMER2 1
`define ESIU_EDGE_FIRST_BIT 0
`define ESIU_EDGE_SECOND_BIT 1
// ------------------------------------------------------------------
// Reset values and answers
// ------------------------------------------------------------------
`define ESIU_RST_BYTE 8'h00
`define ESIU_RESP_OKAY 2'b00
`define ESIU_RESP_SLVERR 2'b10
`define ESIU_VEC_STEP 16'h0004
`endif

// file: core/esiu_top.v
// Eight-source interrupt unit with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "esiu_defs.vh"
module esiu_top #(
    parameter NSRC = 8
) (
    input wire MCLK_I,
    input wire RST_N_I,
    // Raw event lines from timers and filter, and the two pins
    input wire [NSRC-1:0] SRC_EVT_I,
    input wire EXT_PIN_FIRST_I,
    input wire EXT_PIN_SECOND_I,
    // Core handshake
    input wire INT_ACK_I,
    input wire RETI_I,
    input wire [3:0] CODE_BANK_I,
    output wire INT_REQ_O,
    output reg [19:0] INT_VECTOR_O,
    output wire WAKEUP_O,
    output wire [7:0] FLAGS_O,
    // AXI4-Lite slave
    input wire [`ESIU_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output wire S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output wire S_AXI_WREADY_O,
    // Write response
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    // Read address and data
    input wire [`ESIU_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output wire S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Software-visible state first, then pipeline and bus holding state
    reg [7:0] flags_r;          // Processor flags, bit 0 global enable
    reg [7:0] saved_flags_r;    // Copy taken on entry
    reg [7:0] interrupt_mask_r; // Per-source enable
    reg [7:0] interrupt_request_r; // Latched requests
    reg [7:0] system_control_r; // Pin edge selects in bits 1:0
    reg in_service_r;           // Between acknowledge and return
    // Synchroniser stages for the raw event lines and the pin pads
    reg [NSRC-1:0] src_s1_r;    // Synchroniser first stage
    reg [NSRC-1:0] src_s2_r;    // Synchroniser second stage
    reg [NSRC-1:0] src_prev_r;  // Previous synchronised level
    reg [1:0] pin_s1_r;         // Pin synchroniser first stage
    reg [1:0] pin_s2_r;         // Pin synchroniser second stage
    reg [1:0] pin_prev_r;       // Previous synchronised pin level
    // Write channel holding state; one write is committed at a time
    reg [`ESIU_ADDR_W-1:0] aw_addr_r; // Held write address
    reg aw_full_r;              // Write address captured
    reg [31:0] w_data_r;        // Held write data
    reg [3:0] w_strb_r;         // Held strobes
    reg w_full_r;               // Write data captured

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    // Three edges pass from a line change to its request bit
    // A pulse shorter than one clock may be missed, so sources stretch it
    // Sources are asynchronous, so every line passes two flops first
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            src_s1_r <= {NSRC{1'b0}};
            src_s2_r <= {NSRC{1'b0}};
            src_prev_r <= {NSRC{1'b0}};
            pin_s1_r <= 2'b00;
            pin_s2_r <= 2'b00;
            pin_prev_r <= 2'b00;
        end else begin
            src_s1_r <= SRC_EVT_I;
            src_s2_r <= src_s1_r;
            src_prev_r <= src_s2_r;
            // Pin inputs are the pad level, so own output drives are seen too
            pin_s1_r <= {EXT_PIN_SECOND_I, EXT_PIN_FIRST_I};
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // Pin edges compare the settled level with the one a clock earlier
    wire [1:0] pin_rise = pin_s2_r & ~pin_prev_r;
    wire [1:0] pin_fall = ~pin_s2_r & pin_prev_r;
    wire [1:0] edge_sel = {system_control_r[`ESIU_EDGE_SECOND_BIT],
                           system_control_r[`ESIU_EDGE_FIRST_BIT]};
    // Selected edge per pin, 0 rising and 1 falling
    wire [1:0] pin_hit = (pin_rise & ~edge_sel) | (pin_fall & edge_sel);

    // Edge choice only moves the pin slots; other slots ignore it
    // Set events per bit; pin slots take the programmed edge instead
    wire [NSRC-1:0] set_evt;
    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_evt
            if (g == `ESIU_SRC_EXT_FIRST) begin : g_p0
                assign set_evt[g] = pin_hit[0];
            end else if (g == `ESIU_SRC_EXT_SECOND) begin : g_p1
                assign set_evt[g] = pin_hit[1];
            end else begin : g_in
                // Internal sources: rising edge only
                assign set_evt[g] = src_s2_r[g] & ~src_prev_r[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Priority and delivery
    // ------------------------------------------------------------------
    // Masked bits stay latched; only delivery is gated
    wire [7:0] pending = interrupt_request_r & interrupt_mask_r;
    wire gie = flags_r[`ESIU_GIE_BIT];
    assign INT_REQ_O = gie & (|pending);
    // Lowest set bit wins; two's complement isolates it without a loop
    // Fixed order keeps the filter events behind the timers
    wire [7:0] lowest = pending & (~pending + 8'h01);
    reg [15:0] vec_low;
    integer k;
    // Encode chosen source into low vector bits 04H..20H
    always @* begin
        vec_low = 16'h0000;
        for (k = 0; k < 8; k = k + 1) begin
            if (lowest[k]) begin
                vec_low = `ESIU_VEC_STEP * (k[15:0] + 16'h0001);
            end
        end
    end
    // Wake stays high until software clears the Timer2 request bit
    // Timer2 request is an asynchronous-safe level for the clock gate
    assign WAKEUP_O = interrupt_request_r[`ESIU_SRC_TIMER2];
    // Flags go straight out so the core sees the enable it restores
    assign FLAGS_O = flags_r;

    // ------------------------------------------------------------------
    // AXI4-Lite channel handshakes
    // ------------------------------------------------------------------
    // Each half is held until the commit; its ready drops while it waits
    // A new read is taken only once the previous answer is retired
    assign S_AXI_AWREADY_O = ~aw_full_r;
    assign S_AXI_WREADY_O = ~w_full_r;
    assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
    wire wr_go = aw_full_r & w_full_r & ~S_AXI_BVALID_O; // Both halves held, no answer owed
    wire [`ESIU_ADDR_W-1:0] wa = aw_addr_r; // Address of the write being committed
    wire lane0 = wr_go & w_strb_r[0]; // Only byte lane 0 carries register data
    reg hit_sf; // Commit to saved flags
    reg hit_fl; // Commit to flags
    reg hit_mk; // Commit to mask
    reg hit_rq; // Commit to request clears
    reg hit_sc; // Commit to system control
    reg wr_ok; // Address maps to a register

    // Write address decode; strobes fire only in the commit cycle
    always @* begin
        hit_sf = 1'b0;
        hit_fl = 1'b0;
        hit_mk = 1'b0;
        hit_rq = 1'b0;
        hit_sc = 1'b0;
        wr_ok = 1'b1;
        if (wa == `ESIU_ADDR_SAVED_FLAGS) begin
            hit_sf = lane0;
        end else if (wa == `ESIU_ADDR_FLAGS) begin
            hit_fl = lane0;
        end else if (wa == `ESIU_ADDR_INT_MASK) begin
            hit_mk = lane0;
        end else if (wa == `ESIU_ADDR_INT_REQUEST) begin
            hit_rq = lane0;
        end else if (wa == `ESIU_ADDR_SYS_CTL) begin
            hit_sc = lane0;
        end else if (wa == `ESIU_ADDR_STATUS) begin
            // Status is derived, so a write there is answered and dropped
            wr_ok = 1'b1;
        end else begin
            // Unmapped: nothing changes and the answer is an error
            wr_ok = 1'b0;
        end
    end

    // Write channel capture and response
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_addr_r <= {`ESIU_ADDR_W{1'b0}};
            aw_full_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            w_full_r <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `ESIU_RESP_OKAY;
        end else begin
            // Address and data may arrive in either order
            if (S_AXI_AWVALID_I && !aw_full_r) begin
                aw_addr_r <= S_AXI_AWADDR_I;
                aw_full_r <= 1'b1;
            end
            if (S_AXI_WVALID_I && !w_full_r) begin
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
                w_full_r <= 1'b1;
            end
            if (wr_go) begin
                // Both halves present: commit and answer
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_ok ? `ESIU_RESP_OKAY : `ESIU_RESP_SLVERR;
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt state and software-visible registers
    // ------------------------------------------------------------------
    // Acknowledge outranks return, which outranks bus writes to flags
    // A flags write in the acknowledge cycle is lost; service code rewrites it
    // Acknowledge, return and bus writes meet here; set beats clear
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flags_r <= `ESIU_RST_BYTE;
            saved_flags_r <= `ESIU_RST_BYTE;
            interrupt_mask_r <= `ESIU_RST_BYTE;
            interrupt_request_r <= `ESIU_RST_BYTE;
            system_control_r <= `ESIU_RST_BYTE;
            in_service_r <= 1'b0;
        end else begin
            // Zero bits clear, ones are ignored; new events still land
            interrupt_request_r <= (hit_rq ? (interrupt_request_r & w_data_r[7:0])
                                           : interrupt_request_r) | set_evt;
            // Mask and edge selects change only on a committed bus write
            if (hit_mk) begin
                interrupt_mask_r <= w_data_r[7:0];
            end
            if (hit_sc) begin
                system_control_r <= w_data_r[7:0];
            end
            if (INT_ACK_I && INT_REQ_O) begin
                // Entry: keep old flags, drop the global enable
                saved_flags_r <= flags_r;
                flags_r[`ESIU_GIE_BIT] <= 1'b0;
                in_service_r <= 1'b1;
            end else if (RETI_I) begin
                flags_r <= saved_flags_r;
                in_service_r <= 1'b0;
            end else begin
                if (hit_sf) begin
                    saved_flags_r <= w_data_r[7:0];
                end
                if (hit_fl) begin
                    flags_r <= w_data_r[7:0];
                    // Known defect kept on purpose: enable shadows into the copy
                    if (in_service_r && !hit_sf) begin
                        saved_flags_r[`ESIU_GIE_BIT] <= w_data_r[`ESIU_GIE_BIT];
                    end
                end
            end
        end
    end

    // Holding the vector in a flop keeps it steady while the core fetches
    // Vector is captured at acknowledge; upper nibble is the current bank
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INT_VECTOR_O <= 20'h00000;
        end else if (INT_ACK_I && INT_REQ_O) begin
            INT_VECTOR_O <= {CODE_BANK_I, vec_low};
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    reg [7:0] rd_byte; // Register chosen by the read address
    reg rd_err; // Read address maps to nothing
    // Read address decode; unmapped gives zero with an error
    always @* begin
        rd_byte = 8'h00;
        rd_err = 1'b0;
        if (S_AXI_ARADDR_I == `ESIU_ADDR_SAVED_FLAGS) begin
            rd_byte = saved_flags_r;
        end else if (S_AXI_ARADDR_I == `ESIU_ADDR_INT_MASK) begin
            rd_byte = interrupt_mask_r;
        end else if (S_AXI_ARADDR_I == `ESIU_ADDR_INT_REQUEST) begin
            rd_byte = interrupt_request_r;
        end else if (S_AXI_ARADDR_I == `ESIU_ADDR_FLAGS) begin
            rd_byte = flags_r;
        end else if (S_AXI_ARADDR_I == `ESIU_ADDR_SYS_CTL) begin
            rd_byte = system_control_r;
        end else if (S_AXI_ARADDR_I == `ESIU_ADDR_STATUS) begin
            rd_byte = pending;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read answer registers; the answer stands until it is taken
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= `ESIU_RESP_OKAY;
        end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= {24'h000000, rd_byte};
            S_AXI_RRESP_O <= rd_err ? `ESIU_RESP_SLVERR : `ESIU_RESP_OKAY;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

endmodule

// file: dv/esiu_chk.sv
// Port checker for the eight-source interrupt unit
`timescale 1ns/1ps
`include "esiu_defs.vh"
module esiu_chk (
    input wire MCLK_I,
    input wire RST_N_I,
    input wire INT_ACK_I,
    input wire RETI_I,
    input wire [3:0] CODE_BANK_I,
    input wire INT_REQ_O,
    input wire [19:0] INT_VECTOR_O,
    input wire [7:0] FLAGS_O,
    input wire S_AXI_WVALID_I,
    input wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [`ESIU_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    input wire S_AXI_ARREADY_O,
    input wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    input wire [31:0] S_AXI_RDATA_O,
    input wire [1:0] S_AXI_RRESP_O
);
    // ----------------------------------------
    // One clock domain, reset disables all
    // ----------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // Delivery needs the global enable
    gie_gate_a: assert property (INT_REQ_O |-> FLAGS_O[0])
        else $error("request delivered with enable low");
    // Taking an interrupt drops the enable on the next edge
    entry_clr_a: assert property (INT_ACK_I && INT_REQ_O |=> !FLAGS_O[0])
        else $error("enable not cleared at entry");
    // Upper nibble follows the code bank, not the interrupt
    vec_bank_a: assert property (INT_ACK_I && INT_REQ_O
        |=> INT_VECTOR_O[19:16] == $past(CODE_BANK_I))
        else $error("vector bank wrong");
    // Low half lies on the 04H step table
    vec_low_a: assert property (INT_ACK_I && INT_REQ_O |=> INT_VECTOR_O[1:0] == 2'b00
        && INT_VECTOR_O[15:0] inside {[16'h0004:16'h0020]})
        else $error("vector low half off table");
    // Flags move only on entry, return or a bus write
    flags_hold_a: assert property (!INT_ACK_I && !RETI_I && !S_AXI_WVALID_I
        && !$past(S_AXI_WVALID_I) |=> $stable(FLAGS_O))
        else $error("flags changed without cause");
    // Read answer one cycle after the address is taken
    rd_next_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    rd_done_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
        else $error("read answer not retired");
    wr_done_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write answer not retired");
    // Unmapped reads answer zero with an error code
    bad_addr_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        && !(S_AXI_ARADDR_I inside {`ESIU_ADDR_SAVED_FLAGS, `ESIU_ADDR_INT_MASK,
        `ESIU_ADDR_INT_REQUEST, `ESIU_ADDR_FLAGS, `ESIU_ADDR_SYS_CTL, `ESIU_ADDR_STATUS})
        |=> S_AXI_RRESP_O == `ESIU_RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind esiu_top esiu_chk i_esiu_chk (.*);

// file: dv/esiu_core_model.sv
// Processor core stand-in: acknowledges delivered requests, returns on command
`timescale 1ns/1ps
module esiu_core_model (
    input wire clk_i,
    input wire rst_n_i,
    input wire int_req_i,
    input wire [1:0] lat_i,
    input wire ret_i,
    output reg ack_o,
    output reg reti_o
);
    reg [1:0] wait_r; // Cycles the request has waited
    // Ack after lat_i idle cycles; a slow core shows the request must stand
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            reti_o <= 1'b0;
            wait_r <= 2'b00;
        end else begin
            ack_o <= 1'b0;
            reti_o <= ret_i; // Return is a one-cycle pulse from service code
            if (int_req_i && !ack_o) begin
                if (wait_r == lat_i) begin
                    ack_o <= 1'b1;
                    wait_r <= 2'b00;
                end else begin
                    wait_r <= wait_r + 2'b01;
                end
            end else begin
                wait_r <= 2'b00;
            end
        end
    end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the eight-source interrupt unit
`timescale 1ns/1ps
`include "esiu_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    localparam [9:0] a_sav = `ESIU_ADDR_SAVED_FLAGS, a_msk = `ESIU_ADDR_INT_MASK;
    localparam [9:0] a_req = `ESIU_ADDR_INT_REQUEST, a_flg = `ESIU_ADDR_FLAGS;
    localparam [9:0] a_sys = `ESIU_ADDR_SYS_CTL, a_sts = `ESIU_ADDR_STATUS;
    localparam [1:0] ok = `ESIU_RESP_OKAY, se = `ESIU_RESP_SLVERR;
    logic clk = 0, rst_n = 0, p1 = 0, p2 = 0, ret = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] evt = 8'h00;
    logic [1:0] lat = 2'b00;
    logic [3:0] bank = 4'h0;
    logic [9:0] awa = 10'h000, ara = 10'h000;
    logic [31:0] wd = 32'h0;
    wire ack, reti, irq, wake, awr, wr, bv, arr, rv;
    wire [19:0] vec;
    wire [7:0] flg;
    wire [1:0] bresp, rresp;
    wire [31:0] rd;
    int error_cnt = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    esiu_top i_esiu_top (.MCLK_I(clk), .RST_N_I(rst_n), .SRC_EVT_I(evt), .EXT_PIN_FIRST_I(p1),
        .EXT_PIN_SECOND_I(p2), .INT_ACK_I(ack), .RETI_I(reti), .CODE_BANK_I(bank),
        .INT_REQ_O(irq), .INT_VECTOR_O(vec), .WAKEUP_O(wake), .FLAGS_O(flg),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));
    esiu_core_model i_esiu_core_model (.clk_i(clk), .rst_n_i(rst_n), .int_req_i(irq),
        .lat_i(lat), .ret_i(ret), .ack_o(ack), .reti_o(reti));
    // ----------------------------------------
    // Shared tasks; each starts and ends just after a rising edge
    // ----------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tmo; // A wait ran out: count it and stop
        `CHK(1'b0, 1'b1)
        wrap_up;
    endtask
    // Write: both halves offered together, each released once taken
    task axw(input [9:0] a, input [7:0] v, input [1:0] er);
        int k;
        logic ha, hw, hb;
        logic [1:0] r;
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            ha = awv & awr;
            hw = wv & wr;
            hb = bv;
            r = bresp;
            @(posedge clk);
            if (ha) awv <= 0;
            if (hw) wv <= 0;
            if (hb) begin
                br <= 0;
                `CHK(r, er)
                @(posedge clk);
                break;
            end
        end
        if (k == 40) tmo;
    endtask
    task axr(input [9:0] a, input [7:0] ev, input [1:0] er);
        int k;
        logic ha, hr;
        logic [31:0] v;
        logic [1:0] r;
        ara <= a;
        arv <= 1;
        rr <= 1;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            ha = arv & arr;
            hr = rv;
            v = rd;
            r = rresp;
            @(posedge clk);
            if (ha) arv <= 0;
            if (hr) begin
                rr <= 0;
                `CHK(v, {24'h0, ev})
                `CHK(r, er)
                @(posedge clk);
                break;
            end
        end
        if (k == 40) tmo;
    endtask
    // Raise the given sources for two cycles; pins rise too
    task pulse(input [7:0] m);
        evt <= m & 8'hb7;
        p1 <= m[3];
        p2 <= m[6];
        repeat (2) @(posedge clk);
        evt <= 8'h00;
        p1 <= 0;
        p2 <= 0;
        @(posedge clk);
    endtask
    // Wait for the core's ack, then judge vector and enable a cycle on
    task wait_ack(input [19:0] ev);
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            if (ack) break;
        end
        if (k == 40) tmo;
        @(negedge clk);
        `CHK(vec, ev)
        `CHK(flg[0], 1'b0)
        @(posedge clk);
    endtask
    task ret_chk; // Return from service and expect the enable back
        ret <= 1;
        @(posedge clk);
        ret <= 0;
        repeat (3) @(posedge clk);
        `CHK(flg, 8'h01)
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_bus; // Reset values, then unmapped places refused
        axr(a_sav, 8'h00, ok);
        axr(a_msk, 8'h00, ok);
        axr(a_req, 8'h00, ok);
        axr(10'h004, 8'h00, se);
        axw(10'h008, 8'h55, se);
        $display("test bus done");
    endtask
    task t_srcs; // Every source in turn, bank and core latency varied
        int n;
        axw(a_flg, 8'h01, ok);
        axw(a_msk, 8'hff, ok);
        for (n = 0; n < 8; n++) begin
            bank <= n[3:0];
            lat <= n[1:0];
            pulse(8'h01 << n);
            wait_ack({n[3:0], 16'(4 * (n + 1))});
            axr(a_sav, 8'h01, ok);
            axr(a_req, 8'h01 << n, ok);
            if (n == 1) `CHK(wake, 1'b1)
            axw(a_req, ~(8'h01 << n), ok);
            axr(a_req, 8'h00, ok);
            ret_chk;
        end
        $display("test sources done");
    endtask
    task t_mask; // Masked request stays pending and readable
        bank <= 4'h0;
        lat <= 2'd3;
        axw(a_msk, 8'h00, ok);
        pulse(8'h10);
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b0)
        axr(a_req, 8'h10, ok);
        axr(a_sts, 8'h00, ok);
        axw(a_req, 8'hff, ok);
        axr(a_req, 8'h10, ok);
        axw(a_msk, 8'h10, ok);
        wait_ack(20'h00014);
        axr(a_sts, 8'h10, ok);
        axw(a_req, 8'hef, ok);
        ret_chk;
        $display("test mask done");
    endtask
    task t_prio; // Two pending at once: lower number first
        axw(a_flg, 8'h00, ok);
        axw(a_msk, 8'hff, ok);
        pulse(8'h24);
        repeat (3) @(posedge clk);
        axr(a_req, 8'h24, ok);
        axw(a_flg, 8'h01, ok);
        wait_ack(20'h0000c);
        axw(a_req, 8'h00, ok);
        ret_chk;
        $display("test priority done");
    endtask
    task t_defect; // Enable written in service leaks into the saved copy
        pulse(8'h01);
        wait_ack(20'h00004);
        axw(a_flg, 8'h00, ok);
        axr(a_sav, 8'h00, ok);
        axw(a_sav, 8'h01, ok);
        axr(a_sav, 8'h01, ok);
        axw(a_req, 8'hfe, ok);
        ret_chk;
        $display("test defect done");
    endtask
    task t_edge; // Falling polarity on both pins
        axw(a_msk, 8'h00, ok);
        axw(a_sys, 8'h03, ok);
        p1 <= 1;
        p2 <= 1;
        repeat (5) @(posedge clk);
        axr(a_req, 8'h00, ok);
        p1 <= 0;
        p2 <= 0;
        repeat (5) @(posedge clk);
        axr(a_req, 8'h48, ok);
        axw(a_req, 8'h24, ok);
        axr(a_req, 8'h00, ok);
        $display("test edge done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_bus;
        t_srcs;
        t_mask;
        t_prio;
        t_defect;
        t_edge;
        wrap_up;
    end
endmodule
